// ### rtl/cprs_top.sv
// The register offsets and the Avalon-MM register port were decided locally.
`timescale 1ns/10ps
module cprs_top
  import cprs_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic          ce,
  input  wire cprs_avl_req_s avlReq,
  output cprs_avl_rsp_s      avlRsp,
  input  wire logic          pcAdvance,
  input  wire logic [3:0]    pcIncrement,
  input  wire logic          pcLoad,
  input  wire logic [31:0]   pcLoadValue,
  input  wire logic          flagsUpdate,
  input  wire logic [4:0]    flagsValue,
  output cprs_status_s       status
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    cprs_phase_e phase;
    cprs_class_e cls;
    logic [1:0]  resp;
    logic [31:0] readData;
    logic [31:0] wrValue;
    logic [31:0] pc;
    logic [31:0] user_stack_pointer;
    logic [31:0] privileged_stack_pointer;
    logic [15:0] psw;
    logic [2:0]  source_space_code_reg;
    logic [2:0]  dfc;
    logic [31:0] vector_table_base;
  } cprs_state_s;

  cprs_state_s s_r;
  cprs_state_s s_nxt;

  logic                    reqActive;
  logic [`CPRS_IDX_W-1:0]  regIdx;
  cprs_class_e             reqCls;
  cprs_size_e              reqSize;
  logic                    superMode;
  logic [31:0]             oldValue;
  logic [31:0]             opRead;
  logic [31:0]             opMerged;
  logic                    opIsAddr;
  logic [31:0]             memRdata;
  logic                    memWrEn;
  logic [1:0]              fetchResp;

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  function automatic cprs_class_e classOf(input logic [`CPRS_IDX_W-1:0] idx);
    cprs_class_e c;
    c = RC_NONE;
    if (idx <= `CPRS_IDX_DLAST) begin
      c = RC_DATA;
    end else if (idx <= `CPRS_IDX_ALAST) begin
      c = RC_ADDR;
    end else begin
      case (idx)
        `CPRS_IDX_SP:   c = RC_SP;
        `CPRS_IDX_PC:   c = RC_PC;
        `CPRS_IDX_USP:  c = RC_USP;
        `CPRS_IDX_SSP:  c = RC_SSP;
        `CPRS_IDX_PSW:  c = RC_PSW;
        `CPRS_IDX_FLAG: c = RC_FLAG;
        `CPRS_IDX_SFC:  c = RC_SFC;
        `CPRS_IDX_DFC:  c = RC_DFC;
        `CPRS_IDX_VBR:  c = RC_VBR;
        default:        c = RC_NONE;
      endcase
    end
    return c;
  endfunction : classOf

  function automatic cprs_size_e sizeOf(input logic [3:0] be);
    cprs_size_e sz;
    case (be)
      `CPRS_BE_BYTE: sz = SZ_BYTE;
      `CPRS_BE_WORD: sz = SZ_WORD;
      `CPRS_BE_LONG: sz = SZ_LONG;
      default:       sz = SZ_BAD;
    endcase
    return sz;
  endfunction : sizeOf

  // Address-register-like classes: never byte-sized, written whole
  function automatic logic isAddrClass(input cprs_class_e c);
    return (c == RC_ADDR) || (c == RC_SP) || (c == RC_USP) || (c == RC_SSP);
  endfunction : isAddrClass

  // Everything except the flag byte and the user model is supervisor-only
  function automatic logic isPrivClass(input cprs_class_e c);
    return (c == RC_USP) || (c == RC_SSP) || (c == RC_PSW) ||
           (c == RC_SFC) || (c == RC_DFC) || (c == RC_VBR);
  endfunction : isPrivClass

  assign reqActive = avlReq.read | avlReq.write;
  assign regIdx    = avlReq.address[`CPRS_IDX_HI:`CPRS_IDX_LO];
  assign reqCls    = classOf(regIdx);
  assign reqSize   = sizeOf(avlReq.byteenable);
  assign superMode = s_r.psw[`CPRS_PSW_S];
  assign opIsAddr  = isAddrClass(reqCls);

  // ----------------------------------------
  // Data and address register storage
  // ----------------------------------------
  // A quad word is just two data entries the caller picks freely
  cprs_regmem u_regmem (
    .clk    (clk),
    .rst_n  (rst_n),
    .ce     (ce),
    .rdAddr (regIdx[`CPRS_MEM_AW-1:0]),
    .wrEn   (memWrEn),
    .wrAddr (regIdx[`CPRS_MEM_AW-1:0]),
    .wrData (s_r.wrValue),
    .rdData (memRdata)
  ); // RULE5 RULE17

  assign memWrEn = ce && (s_r.phase == PH_DONE) && avlReq.write &&
                   (s_r.resp == `CPRS_RESP_OK) &&
                   ((s_r.cls == RC_DATA) || (s_r.cls == RC_ADDR));

  // ----------------------------------------
  // Current value of the addressed register
  // ----------------------------------------
  always_comb begin
    case (reqCls)
      RC_DATA: oldValue = memRdata;
      RC_ADDR: oldValue = memRdata;
      RC_SP:   oldValue = superMode ? s_r.privileged_stack_pointer : s_r.user_stack_pointer; // RULE18
      RC_PC:   oldValue = s_r.pc;
      RC_USP:  oldValue = s_r.user_stack_pointer;
      RC_SSP:  oldValue = s_r.privileged_stack_pointer;
      RC_PSW:  oldValue = {`CPRS_ZERO16, s_r.psw & `CPRS_PSW_MASK}; // RULE14
      RC_FLAG: oldValue = {`CPRS_ZERO16, s_r.psw & `CPRS_FLAG_MASK}; // RULE15
      RC_SFC:  oldValue = {`CPRS_ZERO29, s_r.source_space_code_reg}; // RULE19
      RC_DFC:  oldValue = {`CPRS_ZERO29, s_r.dfc}; // RULE19
      RC_VBR:  oldValue = s_r.vector_table_base;
      default: oldValue = `CPRS_ZERO32;
    endcase
  end

  cprs_operand u_operand (
    .size        (reqSize),
    .isAddr      (opIsAddr),
    .oldValue    (oldValue),
    .srcValue    (avlReq.writedata),
    .readValue   (opRead),
    .mergedValue (opMerged)
  );

  // ----------------------------------------
  // Legality of the access
  // ----------------------------------------
  always_comb begin
    fetchResp = `CPRS_RESP_OK;
    case (reqCls)
      RC_DATA: begin
        if (reqSize == SZ_BAD) begin
          fetchResp = `CPRS_RESP_SLV;
        end
      end
      RC_ADDR, RC_SP, RC_USP, RC_SSP: begin
        if ((reqSize != SZ_WORD) && (reqSize != SZ_LONG)) begin
          fetchResp = `CPRS_RESP_SLV; // RULE7
        end
      end
      RC_PSW, RC_FLAG: begin
        if (reqSize != SZ_WORD) begin
          fetchResp = `CPRS_RESP_SLV; // RULE15
        end
      end
      RC_PC, RC_SFC, RC_DFC, RC_VBR: begin
        if (reqSize != SZ_LONG) begin
          fetchResp = `CPRS_RESP_SLV;
        end
      end
      default: fetchResp = `CPRS_RESP_DEC;
    endcase
    if (isPrivClass(reqCls) && !superMode) begin
      fetchResp = `CPRS_RESP_SLV; // RULE11 RULE16
    end
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    s_nxt = s_r;

    // Datapath updates first; a bus write in the same cycle overrides them
    if (pcLoad) begin
      s_nxt.pc = pcLoadValue; // RULE10
    end else if (pcAdvance) begin
      s_nxt.pc = s_r.pc + {28'h0000000, pcIncrement}; // RULE10
    end
    if (flagsUpdate) begin
      s_nxt.psw[`CPRS_FLAG_HI:0] = flagsValue; // RULE12
    end

    case (s_r.phase)
      PH_IDLE: begin
        if (reqActive) begin
          s_nxt.phase = PH_FETCH;
        end
      end
      PH_FETCH: begin
        s_nxt.phase    = PH_DONE;
        s_nxt.cls      = reqCls;
        s_nxt.resp     = fetchResp;
        s_nxt.readData = `CPRS_ZERO32;
        if (avlReq.read && (fetchResp == `CPRS_RESP_OK)) begin
          if ((reqCls == RC_DATA) || opIsAddr) begin
            s_nxt.readData = opRead; // RULE2 RULE8
          end else begin
            s_nxt.readData = oldValue;
          end
        end
        case (reqCls)
          RC_DATA: s_nxt.wrValue = opMerged; // RULE3
          RC_ADDR, RC_SP, RC_USP, RC_SSP: begin
            s_nxt.wrValue = opMerged; // RULE9
          end
          RC_PSW: begin
            s_nxt.wrValue = {`CPRS_ZERO16,
                             avlReq.writedata[15:0] & `CPRS_PSW_MASK}; // RULE13 RULE14
          end
          RC_FLAG: begin
            s_nxt.wrValue = {`CPRS_ZERO16,
                             (s_r.psw & ~`CPRS_FLAG_MASK) |
                             (avlReq.writedata[15:0] & `CPRS_FLAG_MASK)}; // RULE15
          end
          RC_SFC, RC_DFC: begin
            s_nxt.wrValue = {`CPRS_ZERO29, avlReq.writedata[`CPRS_FC_HI:0]}; // RULE19
          end
          default: s_nxt.wrValue = avlReq.writedata;
        endcase
      end
      PH_DONE: begin
        s_nxt.phase = PH_IDLE;
        if (avlReq.write && (s_r.resp == `CPRS_RESP_OK)) begin
          case (s_r.cls)
            RC_SP: begin
              if (superMode) begin
                s_nxt.privileged_stack_pointer = s_r.wrValue; // RULE18
              end else begin
                s_nxt.user_stack_pointer = s_r.wrValue; // RULE18
              end
            end
            RC_PC:   s_nxt.pc  = s_r.wrValue; // RULE10
            RC_USP:  s_nxt.user_stack_pointer = s_r.wrValue;
            RC_SSP:  s_nxt.privileged_stack_pointer = s_r.wrValue;
            RC_PSW:  s_nxt.psw = s_r.wrValue[15:0]; // RULE13
            RC_FLAG: s_nxt.psw = s_r.wrValue[15:0]; // RULE12
            RC_SFC:  s_nxt.source_space_code_reg = s_r.wrValue[`CPRS_FC_HI:0];
            RC_DFC:  s_nxt.dfc = s_r.wrValue[`CPRS_FC_HI:0];
            RC_VBR:  s_nxt.vector_table_base = s_r.wrValue;
            default: s_nxt.vector_table_base = s_r.vector_table_base;
          endcase
        end
      end
      default: s_nxt.phase = PH_IDLE;
    endcase
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r          <= '0;
      s_r.phase    <= PH_IDLE;
      s_r.cls      <= RC_NONE;
      s_r.resp     <= `CPRS_RESP_OK;
      s_r.psw      <= `CPRS_PSW_RST;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Three-cycle answer keeps the memory read registered; throughput is traded away
  assign avlRsp.waitrequest = reqActive && (s_r.phase != PH_DONE);
  assign avlRsp.readdata    = s_r.readData;
  assign avlRsp.response    = s_r.resp;

  assign status.supervisor     = superMode; // RULE18
  assign status.traceMode      = s_r.psw[`CPRS_PSW_T_HI:`CPRS_PSW_T_LO]; // RULE13
  assign status.priorityMask   = s_r.psw[`CPRS_PSW_IP_HI:`CPRS_PSW_IP_LO]; // RULE13
  assign status.flags          = s_r.psw[`CPRS_FLAG_HI:0]; // RULE12
  assign status.programCounter = s_r.pc;
  assign status.stackPointer   = superMode ? s_r.privileged_stack_pointer : s_r.user_stack_pointer; // RULE18
  assign status.vectorBase     = s_r.vector_table_base;
  assign status.srcSpace       = s_r.source_space_code_reg;
  assign status.dstSpace       = s_r.dfc;
endmodule : cprs_top

// ### rtl/cprs_cfg.svh
// Function
// RULE1 - Full register set with documented register widths
// RULE2 - Data operand byte/word/long occupy low bits
// RULE3 - Byte/word data writes keep upper bits
// RULE4 - Bit zero is LSB, bit 31 MSB
// RULE5 - Any two data registers hold quad words
// RULE6 - Packed decimal: two nibble digits per byte
// RULE7 - Address registers refuse byte-sized operands
// RULE8 - Address source gives low word or long
// RULE9 - Address destination written whole, word sign-extended
// RULE10 - Program counter advances or loads new value
// RULE11 - Control registers except flag byte need supervisor
// RULE12 - Low status byte holds five flags, user-visible
// RULE13 - Upper byte: priority mask, trace, privilege
// RULE14 - Undefined status bits read zero, write zero
// RULE15 - Status accesses word-size; flag-byte upper reads zero
// RULE16 - User privilege limited to user register model
// RULE17 - Data registers take 1..64-bit operands, addresses
// RULE18 - Privilege bit selects level and stack pointer
// RULE19 - Space codes three bits, upper 29 zero
`ifndef CPRS_CFG_SVH
`define CPRS_CFG_SVH

// ----------------------------------------
// Bus and register indices (byte address = 4 * index)
// ----------------------------------------
`define CPRS_ADDR_W     7
`define CPRS_IDX_LO     2
`define CPRS_IDX_HI     6
`define CPRS_IDX_W      5
`define CPRS_MEM_AW     4
`define CPRS_IDX_DLAST  5'h07
`define CPRS_IDX_ALAST  5'h0E
`define CPRS_IDX_SP     5'h0F
`define CPRS_IDX_PC     5'h10
`define CPRS_IDX_USP    5'h11
`define CPRS_IDX_SSP    5'h12
`define CPRS_IDX_PSW    5'h13
`define CPRS_IDX_FLAG   5'h14
`define CPRS_IDX_SFC    5'h15
`define CPRS_IDX_DFC    5'h16
`define CPRS_IDX_VBR    5'h17

// ----------------------------------------
// Byte enables and responses
// ----------------------------------------
`define CPRS_BE_BYTE    4'h1
`define CPRS_BE_WORD    4'h3
`define CPRS_BE_LONG    4'hF
`define CPRS_RESP_OK    2'h0
`define CPRS_RESP_SLV   2'h2
`define CPRS_RESP_DEC   2'h3

// ----------------------------------------
// Status word layout and reset values
// ----------------------------------------
`define CPRS_PSW_MASK   16'hE71F
`define CPRS_FLAG_MASK  16'h001F
`define CPRS_PSW_RST    16'h2700
`define CPRS_PSW_S      13
`define CPRS_PSW_T_HI   15
`define CPRS_PSW_T_LO   14
`define CPRS_PSW_IP_HI  10
`define CPRS_PSW_IP_LO  8
`define CPRS_FLAG_HI    4
`define CPRS_FC_HI      2
`define CPRS_ZERO32     32'h00000000
`define CPRS_ZERO16     16'h0000
`define CPRS_ZERO29     29'h00000000

`endif

// ### rtl/cprs_pkg.sv
package cprs_pkg;
  `include "cprs_cfg.svh"

  typedef enum logic [1:0] {
    PH_IDLE  = 2'b00,
    PH_FETCH = 2'b01,
    PH_DONE  = 2'b10
  } cprs_phase_e;

  typedef enum logic [1:0] {
    SZ_BYTE = 2'b00,
    SZ_WORD = 2'b01,
    SZ_LONG = 2'b10,
    SZ_BAD  = 2'b11
  } cprs_size_e;

  typedef enum logic [3:0] {
    RC_DATA = 4'b0000,
    RC_ADDR = 4'b0001,
    RC_SP   = 4'b0010,
    RC_PC   = 4'b0011,
    RC_USP  = 4'b0100,
    RC_SSP  = 4'b0101,
    RC_PSW  = 4'b0110,
    RC_FLAG = 4'b0111,
    RC_SFC  = 4'b1000,
    RC_DFC  = 4'b1001,
    RC_VBR  = 4'b1010,
    RC_NONE = 4'b1111
  } cprs_class_e;

  typedef struct packed {
    logic                     read;
    logic                     write;
    logic [`CPRS_ADDR_W-1:0]  address;
    logic [3:0]               byteenable;
    logic [31:0]              writedata;
  } cprs_avl_req_s;

  typedef struct packed {
    logic        waitrequest;
    logic [31:0] readdata;
    logic [1:0]  response;
  } cprs_avl_rsp_s;

  typedef struct packed {
    logic        supervisor;
    logic [1:0]  traceMode;
    logic [2:0]  priorityMask;
    logic [4:0]  flags;
    logic [31:0] programCounter;
    logic [31:0] stackPointer;
    logic [31:0] vectorBase;
    logic [2:0]  srcSpace;
    logic [2:0]  dstSpace;
  } cprs_status_s;

  typedef struct packed {
    logic [15:0][31:0] word;
    logic [31:0]       rdData;
  } cprs_mem_s;
endpackage : cprs_pkg

// ### rtl/cprs_regmem.sv
`timescale 1ns/10ps
module cprs_regmem
  import cprs_pkg::*;
(
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  input  wire logic                     ce,
  input  wire logic [`CPRS_MEM_AW-1:0]  rdAddr,
  input  wire logic                     wrEn,
  input  wire logic [`CPRS_MEM_AW-1:0]  wrAddr,
  input  wire logic [31:0]              wrData,
  output logic      [31:0]              rdData
);
  cprs_mem_s s_r;
  cprs_mem_s s_nxt;

  // ----------------------------------------
  // Storage for data and address registers
  // ----------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.rdData = s_r.word[rdAddr];
    if (wrEn) begin
      s_nxt.word[wrAddr] = wrData; // RULE1
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  assign rdData = s_r.rdData;
endmodule : cprs_regmem

// ### rtl/cprs_operand.sv
`timescale 1ns/10ps
module cprs_operand
  import cprs_pkg::*;
(
  input  wire cprs_size_e  size,
  input  wire logic        isAddr,
  input  wire logic [31:0] oldValue,
  input  wire logic [31:0] srcValue,
  output logic      [31:0] readValue,
  output logic      [31:0] mergedValue
);
  logic [3:0] laneSel;

  always_comb begin
    case (size)
      SZ_BYTE: laneSel = `CPRS_BE_BYTE; // RULE2
      SZ_WORD: laneSel = `CPRS_BE_WORD;
      default: laneSel = `CPRS_BE_LONG;
    endcase
  end

  // ----------------------------------------
  // Per-lane select; bit 0 is the LSB
  // ----------------------------------------
  // Byte lanes pass unchanged, so packed decimal digits keep their nibbles
  genvar lane;
  generate
    for (lane = 0; lane < 4; lane++) begin : gLane
      // Continuous drivers per lane avoid several processes sharing one variable
      assign readValue[lane*8 +: 8] = laneSel[lane] ? oldValue[lane*8 +: 8] : 8'h00; // RULE4 RULE6
      assign mergedValue[lane*8 +: 8] = laneSel[lane] ? srcValue[lane*8 +: 8] :
                                        isAddr        ? {8{srcValue[15]}} // RULE9
                                                      : oldValue[lane*8 +: 8]; // RULE3
    end
  endgenerate
endmodule : cprs_operand

// ### bench/cprs_sva.sv
`timescale 1ns/10ps
`include "cprs_cfg.svh"
module cprs_sva
  import cprs_pkg::*;
(
  input wire logic          clk,
  input wire logic          rst_n,
  input wire logic          ce,
  input wire cprs_avl_req_s avlReq,
  input wire cprs_avl_rsp_s avlRsp,
  input wire logic          pcAdvance,
  input wire logic [3:0]    pcIncrement,
  input wire logic          pcLoad,
  input wire logic [31:0]   pcLoadValue,
  input wire logic          flagsUpdate,
  input wire logic [4:0]    flagsValue,
  input wire cprs_status_s  status
);
  logic       req;
  logic       ans;
  logic       rdOk;
  logic       pcWr;
  logic       fWr;
  logic [4:0] idx;
  assign req  = avlReq.read | avlReq.write;
  assign ans  = req & ~avlRsp.waitrequest & ce;
  assign idx  = avlReq.address[6:2];
  assign rdOk = ans & avlReq.read & (avlRsp.response == `CPRS_RESP_OK);
  // A bus commit to PC or status word overrides the datapath in that cycle
  assign pcWr = ans & avlReq.write & (idx == `CPRS_IDX_PC);
  assign fWr  = ans & avlReq.write & ((idx == `CPRS_IDX_PSW) | (idx == `CPRS_IDX_FLAG));

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence sPending;
    req && avlRsp.waitrequest && ce ##1 avlRsp.waitrequest && ce;
  endsequence

  a_answer_late: assert property (sPending |=> !avlRsp.waitrequest)
    else $error("answer later than third edge");
  a_answer_early: assert property (ans |-> $past(avlRsp.waitrequest) && $past(avlRsp.waitrequest, 2))
    else $error("answer earlier than third edge");
  a_pc_load: assert property (ce && pcLoad && !pcWr |=> status.programCounter == $past(pcLoadValue))
    else $error("program counter load lost");
  a_pc_advance: assert property (ce && pcAdvance && !pcLoad && !pcWr |=>
    status.programCounter == $past(status.programCounter) + $past(pcIncrement))
    else $error("program counter advance wrong");
  a_pc_hold: assert property ((!ce || (!pcAdvance && !pcLoad)) && !pcWr |=>
    $stable(status.programCounter))
    else $error("program counter moved while idle");
  a_flags_take: assert property (ce && flagsUpdate && !fWr |=> status.flags == $past(flagsValue))
    else $error("flag update lost");
  a_refused_zero: assert property (ans && avlRsp.response != `CPRS_RESP_OK |-> avlRsp.readdata == 0)
    else $error("refused access returned data");
  a_addr_byte: assert property (ans && avlReq.byteenable == `CPRS_BE_BYTE &&
    idx > `CPRS_IDX_DLAST && idx <= `CPRS_IDX_SSP |-> avlRsp.response == `CPRS_RESP_SLV)
    else $error("byte access to address register accepted");
  a_user_priv: assert property (ans && !status.supervisor && (idx inside {`CPRS_IDX_USP,
    `CPRS_IDX_SSP, `CPRS_IDX_PSW, `CPRS_IDX_SFC, `CPRS_IDX_DFC, `CPRS_IDX_VBR})
    |-> avlRsp.response == `CPRS_RESP_SLV)
    else $error("privileged register reached in user mode");
  a_psw_zero: assert property (rdOk && idx == `CPRS_IDX_PSW |->
    (avlRsp.readdata & ~{16'h0000, `CPRS_PSW_MASK}) == 0)
    else $error("undefined status bits not zero");
  a_flag_upper: assert property (rdOk && idx == `CPRS_IDX_FLAG |-> avlRsp.readdata[31:5] == 0)
    else $error("flag byte upper bits not zero");
  a_space_upper: assert property (rdOk && idx inside {`CPRS_IDX_SFC, `CPRS_IDX_DFC} |->
    avlRsp.readdata[31:3] == 0)
    else $error("space code upper bits not zero");
  a_unmapped: assert property (ans && idx > `CPRS_IDX_VBR |-> avlRsp.response == `CPRS_RESP_DEC)
    else $error("unmapped index not decode error");
endmodule : cprs_sva

bind cprs_top cprs_sva u_cprs_sva (.clk, .rst_n, .ce, .avlReq, .avlRsp, .pcAdvance,
  .pcIncrement, .pcLoad, .pcLoadValue, .flagsUpdate, .flagsValue, .status);

// ### bench/tb_top.sv
`timescale 1ns/10ps
`include "cprs_cfg.svh"
module tb_top
  import cprs_pkg::*;
;
  localparam logic [1:0] rOk  = `CPRS_RESP_OK;
  localparam logic [1:0] rSlv = `CPRS_RESP_SLV;
  localparam logic [3:0] beB  = `CPRS_BE_BYTE;
  localparam logic [3:0] beW  = `CPRS_BE_WORD;
  localparam logic [3:0] beL  = `CPRS_BE_LONG;
  logic          clk         = 1'h0;
  logic          rst_n       = 1'h0;
  logic          ce          = 1'h1;
  cprs_avl_req_s avlReq      = '0;
  cprs_avl_rsp_s avlRsp;
  logic          pcAdvance   = 1'h0;
  logic [3:0]    pcIncrement = 4'h0;
  logic          pcLoad      = 1'h0;
  logic [31:0]   pcLoadValue = 32'h0;
  logic          flagsUpdate = 1'h0;
  logic [4:0]    flagsValue  = 5'h0;
  cprs_status_s  status;
  int            bad_count   = 0;
  int            samples_checked = 0;
  logic [4:0]    pIdx [6]    = '{5'h11, 5'h12, 5'h13, 5'h15, 5'h16, 5'h17};

  always #50 clk = ~clk;

  cprs_top u_cprs_top (.clk, .rst_n, .ce, .avlReq, .avlRsp, .pcAdvance, .pcIncrement, .pcLoad,
    .pcLoadValue, .flagsUpdate, .flagsValue, .status);

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: saw %h, wanted %h", $time, got, exp);
    end
  endtask : chk

  // -----------------------------------------
  // Bus access: held until waitrequest is seen low
  // -----------------------------------------
  task automatic acc(input logic wr, input logic [4:0] idx, input logic [3:0] be,
                     input logic [31:0] wd, input logic [31:0] expRd, input logic [1:0] expRs);
    avlReq <= {~wr, wr, idx, 2'h0, be, wd};
    // Mid-cycle value is what the next rising edge samples, free of update races
    @(negedge clk);
    while (avlRsp.waitrequest !== 1'h0) @(negedge clk);
    chk(avlRsp.readdata, expRd);
    chk({30'h0, avlRsp.response}, {30'h0, expRs});
    // The answer is taken at this edge; only then is the request released
    @(posedge clk);
    avlReq.read <= 1'h0;
    avlReq.write <= 1'h0;
    // One idle cycle keeps the strobe from being driven twice in one step
    @(posedge clk);
  endtask : acc

  task automatic conclude();
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : conclude

  initial begin
    #200000;
    bad_count++;
    conclude();
  end

  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    chk({31'h0, status.supervisor}, 32'h1);
    acc(1'h0, 5'h13, beW, 32'h0, 32'h00002700, rOk);
    for (int i = 0; i < 8; i++)
      acc(1'h1, 5'(i), beL, 32'(32'h11111111 * (i + 1)), 32'h0, rOk);
    for (int i = 0; i < 8; i++)
      acc(1'h0, 5'(i), beL, 32'h0, 32'(32'h11111111 * (i + 1)), rOk);
    acc(1'h1, 5'h3, beB, 32'hCCCCCCAB, 32'h0, rOk);
    acc(1'h0, 5'h3, beL, 32'h0, 32'h444444AB, rOk);
    acc(1'h1, 5'h3, beW, 32'hDDDDBEEF, 32'h0, rOk);
    acc(1'h0, 5'h3, beL, 32'h0, 32'h4444BEEF, rOk);
    acc(1'h0, 5'h3, beW, 32'h0, 32'h0000BEEF, rOk);
    acc(1'h0, 5'h3, beB, 32'h0, 32'h000000EF, rOk);
    acc(1'h1, 5'h2, beL, 32'h80000097, 32'h0, rOk);
    acc(1'h0, 5'h2, beB, 32'h0, 32'h00000097, rOk);
    acc(1'h0, 5'h2, beL, 32'h0, 32'h80000097, rOk);
    acc(1'h1, 5'h8, beW, 32'h12348001, 32'h0, rOk);
    acc(1'h0, 5'h8, beL, 32'h0, 32'hFFFF8001, rOk);
    acc(1'h0, 5'h8, beW, 32'h0, 32'h00008001, rOk);
    acc(1'h1, 5'h9, beW, 32'hFFFF7FFE, 32'h0, rOk);
    acc(1'h0, 5'h9, beL, 32'h0, 32'h00007FFE, rOk);
    acc(1'h1, 5'h8, beB, 32'h00000055, 32'h0, rSlv);
    acc(1'h0, 5'h8, beL, 32'h0, 32'hFFFF8001, rOk);
    acc(1'h1, 5'h12, beL, 32'h0000A000, 32'h0, rOk);
    acc(1'h1, 5'h11, beL, 32'h0000B000, 32'h0, rOk);
    acc(1'h1, 5'h12, beB, 32'h00000077, 32'h0, rSlv);
    chk(status.stackPointer, 32'h0000A000);
    acc(1'h0, 5'hF, beL, 32'h0, 32'h0000A000, rOk);
    acc(1'h1, 5'h13, beW, 32'h0000FFFF, 32'h0, rOk);
    acc(1'h0, 5'h13, beW, 32'h0, 32'h0000E71F, rOk);
    chk({30'h0, status.traceMode}, 32'h3);
    chk({29'h0, status.priorityMask}, 32'h7);
    acc(1'h0, 5'h13, beL, 32'h0, 32'h0, rSlv);
    acc(1'h1, 5'h15, beL, 32'hFFFFFFFD, 32'h0, rOk);
    acc(1'h0, 5'h15, beL, 32'h0, 32'h00000005, rOk);
    acc(1'h1, 5'h16, beL, 32'h0000000A, 32'h0, rOk);
    acc(1'h0, 5'h16, beL, 32'h0, 32'h00000002, rOk);
    chk({29'h0, status.srcSpace}, 32'h5);
    chk({29'h0, status.dstSpace}, 32'h2);
    acc(1'h1, 5'h17, beL, 32'h00012300, 32'h0, rOk);
    acc(1'h0, 5'h17, beL, 32'h0, 32'h00012300, rOk);
    chk(status.vectorBase, 32'h00012300);
    flagsUpdate <= 1'h1;
    flagsValue <= 5'h15;
    @(posedge clk);
    flagsUpdate <= 1'h0;
    @(posedge clk);
    chk({27'h0, status.flags}, 32'h15);
    acc(1'h0, 5'h14, beW, 32'h0, 32'h00000015, rOk);
    acc(1'h1, 5'h14, beW, 32'hFFFFFF0A, 32'h0, rOk);
    acc(1'h0, 5'h13, beW, 32'h0, 32'h0000E70A, rOk);
    acc(1'h1, 5'h14, beB, 32'h00000003, 32'h0, rSlv);
    // Load and advance together: the load must win
    pcLoad <= 1'h1;
    pcLoadValue <= 32'h00001000;
    pcAdvance <= 1'h1;
    pcIncrement <= 4'h4;
    @(posedge clk);
    pcLoad <= 1'h0;
    repeat (3) @(posedge clk);
    pcIncrement <= 4'hF;
    @(posedge clk);
    ce <= 1'h0;
    repeat (2) @(posedge clk);
    pcAdvance <= 1'h0;
    ce <= 1'h1;
    @(posedge clk);
    chk(status.programCounter, 32'h0000101B);
    acc(1'h0, 5'h10, beL, 32'h0, 32'h0000101B, rOk);
    acc(1'h1, 5'h10, beL, 32'h00002000, 32'h0, rOk);
    chk(status.programCounter, 32'h00002000);
    acc(1'h1, 5'h13, beW, 32'h0000001F, 32'h0, rOk);
    chk(status.stackPointer, 32'h0000B000);
    acc(1'h0, 5'hF, beL, 32'h0, 32'h0000B000, rOk);
    acc(1'h1, 5'hF, beL, 32'h0000C000, 32'h0, rOk);
    chk(status.stackPointer, 32'h0000C000);
    for (int i = 0; i < 6; i++)
      acc(1'h0, pIdx[i], (pIdx[i] == 5'h13) ? beW : beL, 32'h0, 32'h0, rSlv);
    acc(1'h0, 5'h14, beW, 32'h0, 32'h0000001F, rOk);
    acc(1'h0, 5'h3, beL, 32'h0, 32'h4444BEEF, rOk);
    acc(1'h1, 5'h13, beW, 32'h00002000, 32'h0, rSlv);
    chk({31'h0, status.supervisor}, 32'h0);
    acc(1'h0, 5'h19, beL, 32'h0, 32'h0, `CPRS_RESP_DEC);
    conclude();
  end
endmodule : tb_top
